/* File: common/ioc_pkg.sv */
package ioc_pkg;
    // register indices on the plain port
    localparam logic [1:0] ADDR_TUNING  = 2'h0;
    localparam logic [1:0] ADDR_CONTROL = 2'h1;
    localparam logic [1:0] ADDR_TIMER1  = 2'h2;
    localparam logic [1:0] ADDR_STATUS  = 2'h3;
    // tuning register fields
    localparam int TUN_LFSRC_BIT = 7;
    localparam int TUN_MULT_BIT  = 6;
    localparam logic [7:0] TUNING_RESET = 8'h00;
    // control register fields
    localparam int CTL_IDLE_BIT = 7;
    localparam int CTL_STARTUP_TIMER_DONE_BIT = 3;
    localparam int CTL_INTERNAL_STABLE_FLAG_BIT = 2;
    localparam logic [2:0] IFS_RESET = 3'h4;   // 1 MHz
    localparam logic [2:0] IFS_8M    = 3'h7;
    localparam logic [2:0] IFS_4M    = 3'h6;
    localparam logic [2:0] IFS_31K   = 3'h0;
    localparam logic [1:0] SCS_PRI   = 2'h0;
    localparam logic [1:0] SCS_SEC   = 2'h1;
    // timer1 control fields
    localparam int T1_RUN_BIT = 6;
    localparam int T1_OSC_BIT = 3;
    // primary configuration encodings
    localparam logic [3:0] CFG_INT_A = 4'h9;
    localparam logic [3:0] CFG_INT_B = 4'h8;
    // switch pause: old cycles and new cycles
    localparam logic [2:0] SW_OLD = 3'h2;
    localparam logic [2:0] SW_NEW = 3'h4;

    typedef enum logic [1:0] {SRC_PRI, SRC_SEC, SRC_INT} ioc_src_t;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ioc_bus_t;
endpackage

/* File: dv/ioc_clock_ctrl_asserts.sv */
module ioc_clock_ctrl_asserts (
    // clock and reset
    input wire logic              mclk,
    input wire logic              reset,
    // register port
    input wire ioc_pkg::ioc_bus_t bus,
    input wire logic [7:0]        rdata,
    // sleep request and steering outputs
    input wire logic              sleepExec,
    input wire logic              multEnable,
    input wire logic [2:0]        internalFreqSelect,
    input wire logic              lowFreqFromFast,
    input wire logic              wdtFromSlowRc,
    input wire logic [1:0]        activeSource,
    input wire logic              clockHold,
    input wire logic              enterSleep,
    input wire logic              enterIdle
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (reset);
    // switch pause: old-source part then new-source part
    sequence holdOld;
        clockHold[*2];
    endsequence
    sequence holdNew;
        clockHold[*3] ##[1:2] !clockHold;
    endsequence
    AST_HOLD: assert property ($rose(clockHold) |-> holdOld ##1 holdNew)
        else $error("clock switch pause length wrong");
    AST_MULT: assert property (multEnable |-> internalFreqSelect[2:1] == 2'h3)
        else $error("multiplier on outside 4 or 8 MHz");
    AST_LOWF: assert property (lowFreqFromFast |-> internalFreqSelect == 3'h0)
        else $error("fast 31k source outside 31k setting");
    AST_WDT: assert property (wdtFromSlowRc)
        else $error("watchdog clock left slow rc");
    AST_RDZ: assert property (!$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data without read");
    AST_SLEEP: assert property (sleepExec |=> enterSleep != enterIdle)
        else $error("sleep request gave no single mode");
    AST_QUIET: assert property (!sleepExec |=> !enterSleep && !enterIdle)
        else $error("sleep mode without request");
    AST_RST: assert property ($fell(reset) |-> activeSource == 2'h0 &&
        internalFreqSelect == 3'h4) else $error("reset values wrong");
    AST_SRC: assert property (activeSource != 2'h3)
        else $error("illegal active source");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind ioc_clock_ctrl ioc_clock_ctrl_asserts ioc_clock_ctrl_asserts_i (.mclk, .reset, .bus,
    .rdata, .sleepExec, .multEnable, .internalFreqSelect, .lowFreqFromFast, .wdtFromSlowRc,
    .activeSource, .clockHold, .enterSleep, .enterIdle);

/* File: dv/ioc_clock_ctrl_test.sv */
module ioc_clock_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [3:0] cfg;
        logic [7:0] ctl;
        logic [7:0] tun;
        logic [7:0] rb;
        logic       mult;
        logic       low;
    } ioc_row_t;
    logic              mclk, reset, sleepExec, startup_timer_done, internal_stable_flag, mult, low, wdt, hold, slp, idl;
    logic [3:0]        cfg;
    logic [7:0]        rdata, v;
    logic signed [4:0] trim;
    logic [2:0]        ifs;
    logic [1:0]        src;
    ioc_pkg::ioc_bus_t bus;
    int                failures, tests_run;
    ioc_row_t rows [6] = '{'{4'h9, 8'h70, 8'h5F, 8'h5F, 1'b1, 1'b0},
        '{4'h8, 8'h60, 8'h50, 8'h50, 1'b1, 1'b0}, '{4'h9, 8'h50, 8'h40, 8'h40, 1'b0, 1'b0},
        '{4'h6, 8'h70, 8'h40, 8'h00, 1'b0, 1'b0}, '{4'h9, 8'h00, 8'h80, 8'h80, 1'b0, 1'b1},
        '{4'h9, 8'h70, 8'hA0, 8'h80, 1'b0, 1'b0}};
    ioc_clock_ctrl ioc_clock_ctrl_i (.mclk(mclk), .reset(reset), .bus(bus), .rdata(rdata),
        .primary_osc_config(cfg), .startupTimerExpired(startup_timer_done), .fastOscStable(internal_stable_flag),
        .sleepExec(sleepExec), .multEnable(mult), .freqTrim(trim), .internalFreqSelect(ifs),
        .lowFreqFromFast(low), .wdtFromSlowRc(wdt), .activeSource(src), .clockHold(hold),
        .enterSleep(slp), .enterIdle(idl));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge mclk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        @(negedge mclk);
        d = rdata;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic print_verdict;
        if (failures == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        failures++;
        print_verdict();
    end
    initial begin
        {reset, sleepExec, startup_timer_done, internal_stable_flag, cfg, bus} = {1'b1, 3'h0, 4'h9, 12'h000};
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        rd(ioc_pkg::ADDR_TUNING, v);
        chk("tuning", 8'h00, v);
        rd(ioc_pkg::ADDR_CONTROL, v);
        chk("control", 8'h40, v & 8'hF3);
        chk("outs", 8'h84, {wdt, src, mult, low, ifs});
        foreach (rows[i]) begin
            @(posedge mclk);
            cfg <= rows[i].cfg;
            wr(ioc_pkg::ADDR_CONTROL, rows[i].ctl);
            wr(ioc_pkg::ADDR_TUNING, rows[i].tun);
            rd(ioc_pkg::ADDR_TUNING, v);
            chk("tuning", rows[i].rb, v);
            wt(2);
            chk("mult", {7'h00, rows[i].mult}, {7'h00, mult});
            chk("low", {7'h00, rows[i].low}, {7'h00, low});
            chk("trim", {3'h0, rows[i].tun[4:0]}, {3'h0, trim});
            chk("ifs", {5'h00, rows[i].ctl[6:4]}, {5'h00, ifs});
        end
        wr(ioc_pkg::ADDR_CONTROL, 8'h71);
        rd(ioc_pkg::ADDR_CONTROL, v);
        chk("refused", 8'h70, v);
        wr(ioc_pkg::ADDR_TIMER1, 8'h08);
        wr(ioc_pkg::ADDR_CONTROL, 8'h71);
        wt(20);
        chk("secondary", 8'h01, {5'h00, hold, src});
        rd(ioc_pkg::ADDR_TIMER1, v);
        chk("secondary_running_flag", 8'h48, v);
        @(posedge mclk);
        internal_stable_flag <= 1'b1;
        wr(ioc_pkg::ADDR_CONTROL, 8'h72);
        wt(20);
        chk("internal", 8'h02, {6'h00, src});
        rd(ioc_pkg::ADDR_CONTROL, v);
        chk("internal_stable_flag", 8'h76, v);
        rd(ioc_pkg::ADDR_TIMER1, v);
        chk("secondary_running_flag", 8'h08, v);
        @(posedge mclk);
        startup_timer_done <= 1'b1;
        wr(ioc_pkg::ADDR_CONTROL, 8'h70);
        wt(20);
        rd(ioc_pkg::ADDR_CONTROL, v);
        chk("startup_timer_done", 8'h78, v);
        for (int k = 0; k < 2; k++) begin
            wr(ioc_pkg::ADDR_CONTROL, {k[0], 7'h70});
            sleepExec <= 1'b1;
            @(posedge mclk);
            sleepExec <= 1'b0;
            @(negedge mclk);
            chk("sleep", {6'h00, k[0], ~k[0]}, {6'h00, idl, slp});
        end
        rd(ioc_pkg::ADDR_STATUS, v);
        chk("unmapped", 8'h00, v);
        // mid-run reset while running from the internal block
        wr(ioc_pkg::ADDR_CONTROL, 8'h72);
        wt(20);
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        rd(ioc_pkg::ADDR_TUNING, v);
        chk("tuning after reset", 8'h00, v);
        rd(ioc_pkg::ADDR_CONTROL, v);
        chk("control after reset", 8'h40, v & 8'hF3);
        chk("source after reset", 8'h00, {6'h00, src});
        print_verdict();
    end
endmodule

/* File: rtl/ioc_clock_ctrl.sv */
module ioc_clock_ctrl (
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          reset,
    // register port
    input  wire ioc_pkg::ioc_bus_t bus,
    output logic [7:0]         rdata,
    // configuration, oscillator status and sleep request
    input  wire logic [3:0]    primary_osc_config,
    input  wire logic          startupTimerExpired,
    input  wire logic          fastOscStable,
    input  wire logic          sleepExec,
    // clock steering outputs
    output logic               multEnable,
    output logic signed [4:0]  freqTrim,
    output logic [2:0]         internalFreqSelect,
    output logic               lowFreqFromFast,
    output logic               wdtFromSlowRc,
    output logic [1:0]         activeSource,
    output logic               clockHold,
    output logic               enterSleep,
    output logic               enterIdle
);
    ////////////////////////////////////////////////////////////////////////
    // registers
    logic       lfSrc, multBit, idleOnSleep, t1Other, secondary_osc_enable;
    logic [4:0] trim;
    logic [2:0] ifs;
    logic [1:0] scs;
    logic       next_lfSrc, next_multBit, next_idleOnSleep, next_t1Other, next_secondary_osc_enable;
    logic [4:0] next_trim;
    logic [2:0] next_ifs;
    logic [1:0] next_scs;
    logic       cfgOk, freqOk, avail;
    logic [2:0] syncOst, syncStab;
    logic       ostDone, intStable;

    assign cfgOk  = (primary_osc_config == ioc_pkg::CFG_INT_A) ||
                    (primary_osc_config == ioc_pkg::CFG_INT_B);
    assign freqOk = (ifs == ioc_pkg::IFS_8M) || (ifs == ioc_pkg::IFS_4M);
    assign avail  = cfgOk;

    always_comb begin
        next_lfSrc = lfSrc;
        next_multBit = multBit & avail;
        next_trim = trim;
        next_idleOnSleep = idleOnSleep;
        next_ifs = ifs;
        next_scs = scs;
        next_t1Other = t1Other;
        next_secondary_osc_enable = secondary_osc_enable;
        if (bus.wr) begin
            case (bus.addr)
                ioc_pkg::ADDR_TUNING: begin
                    next_lfSrc = bus.wdata[ioc_pkg::TUN_LFSRC_BIT];
                    next_multBit = bus.wdata[ioc_pkg::TUN_MULT_BIT] & avail;
                    next_trim = bus.wdata[4:0];
                end
                ioc_pkg::ADDR_CONTROL: begin
                    next_idleOnSleep = bus.wdata[ioc_pkg::CTL_IDLE_BIT];
                    next_ifs = bus.wdata[6:4];
                    if (bus.wdata[1:0] != ioc_pkg::SCS_SEC || secondary_osc_enable)
                        next_scs = bus.wdata[1:0];
                end
                ioc_pkg::ADDR_TIMER1: begin
                    next_secondary_osc_enable = bus.wdata[ioc_pkg::T1_OSC_BIT];
                    next_t1Other = bus.wdata[0];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            lfSrc <= ioc_pkg::TUNING_RESET[ioc_pkg::TUN_LFSRC_BIT];
            multBit <= ioc_pkg::TUNING_RESET[ioc_pkg::TUN_MULT_BIT];
            trim <= ioc_pkg::TUNING_RESET[4:0];
            idleOnSleep <= 1'b0;
            ifs <= ioc_pkg::IFS_RESET;
            scs <= ioc_pkg::SCS_PRI;
            t1Other <= 1'b0;
            secondary_osc_enable <= 1'b0;
        end else begin
            lfSrc <= next_lfSrc;
            multBit <= next_multBit;
            trim <= next_trim;
            idleOnSleep <= next_idleOnSleep;
            ifs <= next_ifs;
            scs <= next_scs;
            t1Other <= next_t1Other;
            secondary_osc_enable <= next_secondary_osc_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status input synchronisers
    always_ff @(posedge mclk) begin
        if (reset) begin
            syncOst <= 3'h0;
            syncStab <= 3'h0;
            ostDone <= 1'b0;
            intStable <= 1'b0;
        end else begin
            syncOst <= {syncOst[1:0], startupTimerExpired};
            syncStab <= {syncStab[1:0], fastOscStable};
            if (syncOst[1] == syncOst[2])
                ostDone <= syncOst[2];
            if (syncStab[1] == syncStab[2])
                intStable <= syncStab[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock switch sequencer
    typedef enum logic [1:0] {SW_RUN, SW_OLDWAIT, SW_NEWWAIT} ioc_sw_t;
    ioc_sw_t    swState, next_swState;
    logic [2:0] swCnt, next_swCnt;
    ioc_pkg::ioc_src_t src, next_src, want;

    always_comb begin
        case (scs)
            ioc_pkg::SCS_PRI: want = ioc_pkg::SRC_PRI;
            ioc_pkg::SCS_SEC: want = ioc_pkg::SRC_SEC;
            default:          want = ioc_pkg::SRC_INT;
        endcase
        next_swState = swState;
        next_swCnt = swCnt;
        next_src = src;
        case (swState)
            SW_RUN: begin
                if (want != src) begin
                    next_swState = SW_OLDWAIT;
                    next_swCnt = 3'h1;
                end
            end
            SW_OLDWAIT: begin
                if (swCnt == ioc_pkg::SW_OLD) begin
                    next_swState = SW_NEWWAIT;
                    next_swCnt = 3'h1;
                    next_src = want;
                end else
                    next_swCnt = swCnt + 3'h1;
            end
            SW_NEWWAIT: begin
                if (swCnt == ioc_pkg::SW_NEW)
                    next_swState = SW_RUN;
                else
                    next_swCnt = swCnt + 3'h1;
            end
            default: next_swState = SW_RUN;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            swState <= SW_RUN;
            swCnt <= 3'h0;
            src <= ioc_pkg::SRC_PRI;
        end else begin
            swState <= next_swState;
            swCnt <= next_swCnt;
            src <= next_src;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs and read data
    logic [7:0] next_rdata;
    logic       fOsts, fIofs, fT1run;

    always_comb begin
        fOsts  = ostDone && src == ioc_pkg::SRC_PRI;
        fIofs  = intStable && src == ioc_pkg::SRC_INT &&
                 !(ifs == ioc_pkg::IFS_31K && !lfSrc);
        fT1run = src == ioc_pkg::SRC_SEC;
        next_rdata = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                ioc_pkg::ADDR_TUNING:
                    next_rdata = {lfSrc, multBit & avail, 1'b0, trim};
                ioc_pkg::ADDR_CONTROL:
                    next_rdata = {idleOnSleep, ifs, fOsts, fIofs, scs};
                ioc_pkg::ADDR_TIMER1:
                    next_rdata = {1'b0, fT1run, 2'h0, secondary_osc_enable, 2'h0, t1Other};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata <= 8'h00;
            multEnable <= 1'b0;
            freqTrim <= signed'(ioc_pkg::TUNING_RESET[4:0]);
            internalFreqSelect <= ioc_pkg::IFS_RESET;
            lowFreqFromFast <= 1'b0;
            wdtFromSlowRc <= 1'b1;
            activeSource <= 2'h0;
            clockHold <= 1'b0;
            enterSleep <= 1'b0;
            enterIdle <= 1'b0;
        end else begin
            rdata <= next_rdata;
            multEnable <= multBit & cfgOk & freqOk;
            freqTrim <= signed'(trim);
            internalFreqSelect <= ifs;
            lowFreqFromFast <= (ifs == ioc_pkg::IFS_31K) & lfSrc;
            wdtFromSlowRc <= 1'b1;
            activeSource <= src;
            clockHold <= next_swState != SW_RUN;
            enterSleep <= sleepExec & ~idleOnSleep;
            enterIdle <= sleepExec & idleOnSleep;
        end
    end
endmodule
